//--- shared/urs_pkg.sv
`default_nettype none
package urs_pkg;
    // ***************************************************
    // Register offsets (byte addresses)
    // ***************************************************
    localparam logic [7:0] URS_OFS_STATUS = 8'h00;
    localparam logic [7:0] URS_OFS_MODE = 8'h04;
    localparam logic [7:0] URS_OFS_BAUD = 8'h08;
    localparam logic [7:0] URS_OFS_DATA = 8'h0C;
    localparam logic [7:0] URS_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] URS_OFS_IRQ_MASK = 8'h14;
    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int URS_STA_SEL_LO = 6;
    localparam int URS_STA_ADDR_EN = 5;
    localparam int URS_STA_IDLE = 4;
    localparam int URS_STA_PARITY_ERROR_FLAG = 3;
    localparam int URS_STA_FRAMING_ERROR_FLAG = 2;
    localparam int URS_STA_OVERRUN_ERROR_FLAG = 1;
    localparam int URS_STA_AVAIL = 0;
    localparam int URS_MODE_NINE = 0;
    localparam int URS_MODE_PAR_EN = 1;
    localparam int URS_MODE_PAR_ODD = 2;
    localparam int URS_IRQ_W = 5;
    localparam int URS_EV_LEVEL = 0;
    localparam int URS_EV_OVERRUN = 1;
    localparam int URS_EV_PARITY = 2;
    localparam int URS_EV_FRAMING = 3;
    localparam int URS_EV_ADDRESS = 4;
    // ***************************************************
    // Reset values and timing
    // ***************************************************
    localparam logic [1:0] URS_SEL_RESET = 2'h0;
    localparam logic [2:0] URS_MODE_RESET = 3'h0;
    localparam logic [URS_IRQ_W-1:0] URS_MASK_RESET = 5'h00;
    localparam int URS_CLK_HZ = 50_000_000;
    localparam int URS_BAUD_DEFAULT = 115_200;
    localparam logic [15:0] URS_BAUD_RESET = 16'(URS_CLK_HZ / URS_BAUD_DEFAULT);
    // ***************************************************
    // Threshold selection codes
    // ***************************************************
    typedef enum logic [1:0] {
        URS_SEL_ANY = 2'b00,
        URS_SEL_HALF = 2'b01,
        URS_SEL_3Q = 2'b10,
        URS_SEL_RSVD = 2'b11
    } urs_sel_t;
endpackage
`default_nettype wire

//--- design/urs_rx_fifo.sv
`default_nettype none
module urs_rx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8,
    localparam int AW = $clog2(DEPTH),
    localparam int CW = $clog2(DEPTH + 1)
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    import urs_pkg::*;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    // Pushes into a full buffer are refused here; overrun is judged upstream
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign full = count == CW'(DEPTH);
    assign empty = count == '0;
    assign head = mem[rd_ptr];

    // Storage, no reset needed since count gates every read
    always_ff @(posedge clock) begin
        if (clk_en && do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // Pointers and fill level; flush outranks traffic
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clk_en) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (do_push) begin
                    wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
                end
                if (do_pop) begin
                    rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
                end
                if (do_push && !do_pop) begin
                    count <= count + 1'b1;
                end else if (do_pop && !do_push) begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- design/urs_rx_shift.sv
`default_nettype none
module urs_rx_shift (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic rx_line,
    input wire logic [15:0] bit_ticks,
    input wire logic nine_bit,
    input wire logic parity_en,
    input wire logic parity_odd,
    output logic char_valid,
    output logic [8:0] char_data,
    output logic char_parity_error_flag,
    output logic char_framing_error_flag,
    output logic idle
);
    import urs_pkg::*;
    typedef enum logic [2:0] {
        URS_ST_IDLE = 3'b000,
        URS_ST_START = 3'b001,
        URS_ST_DATA = 3'b010,
        URS_ST_PARITY = 3'b011,
        URS_ST_STOP = 3'b100
    } urs_rx_state_t;
    urs_rx_state_t state;
    logic [15:0] cnt;
    logic [3:0] bit_idx;
    logic [8:0] receive_shift_register;
    logic par;
    logic tick;

    assign tick = cnt == '0;
    assign idle = state == URS_ST_IDLE;

    // Bit timing: half a bit to the start centre, then whole bits
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= URS_ST_IDLE;
            cnt <= '0;
            bit_idx <= '0;
            receive_shift_register <= '0;
            par <= 1'b0;
            char_valid <= 1'b0;
            char_data <= '0;
            char_parity_error_flag <= 1'b0;
            char_framing_error_flag <= 1'b0;
        end else if (clk_en) begin
            char_valid <= 1'b0;
            if (flush) begin
                state <= URS_ST_IDLE;
                receive_shift_register <= '0;
            end else begin
                cnt <= tick ? bit_ticks - 1'b1 : cnt - 1'b1;
                case (state)
                    URS_ST_IDLE: begin
                        if (!rx_line) begin
                            state <= URS_ST_START;
                            cnt <= {1'b0, bit_ticks[15:1]};
                        end
                    end
                    URS_ST_START: begin
                        if (tick) begin
                            // A start bit gone high at its centre was a glitch
                            state <= rx_line ? URS_ST_IDLE : URS_ST_DATA;
                            bit_idx <= '0;
                            par <= 1'b0;
                            char_parity_error_flag <= 1'b0;
                        end
                    end
                    URS_ST_DATA: begin
                        if (tick) begin
                            receive_shift_register <= {rx_line, receive_shift_register[8:1]};
                            par <= par ^ rx_line;
                            bit_idx <= bit_idx + 1'b1;
                            if (bit_idx == (nine_bit ? 4'h8 : 4'h7)) begin
                                state <= (parity_en && !nine_bit) ? URS_ST_PARITY : URS_ST_STOP;
                            end
                        end
                    end
                    URS_ST_PARITY: begin
                        if (tick) begin
                            char_parity_error_flag <= par ^ rx_line ^ parity_odd;
                            state <= URS_ST_STOP;
                        end
                    end
                    URS_ST_STOP: begin
                        if (tick) begin
                            char_framing_error_flag <= !rx_line;
                            char_valid <= 1'b1;
                            char_data <= nine_bit ? receive_shift_register
                                                  : {1'b0, receive_shift_register[8:1]};
                            state <= URS_ST_IDLE;
                        end
                    end
                    default: begin
                        state <= URS_ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- design/urs_rx_status.sv
// Implementation choices: strobed register access and the register offsets.
`default_nettype none
module urs_rx_status
    import urs_pkg::*;
#(
    parameter int DEPTH = 8,
    localparam int CW = $clog2(DEPTH + 1)
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic rx_line,
    output logic rx_irq_flag,
    output logic irq
);
    // ***************************************************
    // Elaboration checks
    // ***************************************************
    // Quarter thresholds need a depth that divides by four
    if (DEPTH < 4 || (DEPTH % 4) != 0) begin : g_bad_depth
        $error("urs_rx_status: DEPTH must be a multiple of four, at least four");
    end

    localparam logic [CW-1:0] LVL_HALF = CW'(DEPTH / 2);
    localparam logic [CW-1:0] LVL_3Q = CW'((DEPTH * 3) / 4);

    // ***************************************************
    // Software state
    // ***************************************************
    logic [1:0] rx_irq_threshold_sel;
    logic address_detect_enable;
    logic overrun_error_flag;
    logic [2:0] mode;
    logic [15:0] bit_ticks;
    logic [URS_IRQ_W-1:0] irq_status;
    logic [URS_IRQ_W-1:0] irq_mask;
    logic prev_level;

    // ***************************************************
    // Internal wires
    // ***************************************************
    logic char_valid;
    logic [8:0] char_data;
    logic char_parity_error_flag;
    logic char_framing_error_flag;
    logic receiver_idle_flag;
    logic [10:0] head;
    logic [CW-1:0] count;
    logic full;
    logic empty;
    logic wr_status;
    logic rd_data;
    logic accept;
    logic push;
    logic overflow;
    logic overrun_error_flag_clear;
    logic flush;
    logic rx_data_available;
    logic parity_error_flag;
    logic framing_error_flag;
    logic next_level;
    logic [URS_IRQ_W-1:0] events;
    logic [31:0] next_rdata;

    // ***************************************************
    // Bus decode
    // ***************************************************
    assign wr_status = reg_write && reg_addr == URS_OFS_STATUS;
    assign rd_data = reg_read && reg_addr == URS_OFS_DATA;

    // ***************************************************
    // Receive path
    // ***************************************************
    // Character assembly from the serial line
    urs_rx_shift u_shift (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .flush(flush),
        .rx_line(rx_line),
        .bit_ticks(bit_ticks),
        .nine_bit(mode[URS_MODE_NINE]),
        .parity_en(mode[URS_MODE_PAR_EN]),
        .parity_odd(mode[URS_MODE_PAR_ODD]),
        .char_valid(char_valid),
        .char_data(char_data),
        .char_parity_error_flag(char_parity_error_flag),
        .char_framing_error_flag(char_framing_error_flag),
        .idle(receiver_idle_flag)
    );

    // Address filter: in 9-bit mode with detect on, data characters are dropped
    assign accept = !(address_detect_enable && mode[URS_MODE_NINE]) || char_data[8];

    // Nothing is stored while an overrun is pending, so software sees the
    // buffer exactly as it stood when the loss happened
    assign push = char_valid && accept && !full && !overflow_pending();
    assign overflow = char_valid && accept && full;

    function automatic logic overflow_pending();
        return overrun_error_flag;
    endfunction

    // Clearing a set overrun flag empties buffer and shift register
    assign overrun_error_flag_clear = wr_status && !reg_wdata[URS_STA_OVERRUN_ERROR_FLAG] && overrun_error_flag;
    assign flush = overrun_error_flag_clear;

    // Receive buffer holding data plus per-character error marks
    urs_rx_fifo #(
        .WIDTH(11),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .flush(flush),
        .push(push),
        .push_data({char_framing_error_flag, char_parity_error_flag, char_data}),
        .pop(rd_data),
        .head(head),
        .count(count),
        .full(full),
        .empty(empty)
    );

    // ***************************************************
    // Status flags
    // ***************************************************
    // Parity and framing error flags describe the character at the head of the buffer
    assign rx_data_available = !empty;
    assign parity_error_flag = !empty && head[9];
    assign framing_error_flag = !empty && head[10];

    // Threshold level from the selection field, recomputed every cycle
    always_comb begin
        case (urs_sel_t'(rx_irq_threshold_sel))
            URS_SEL_ANY: next_level = count != '0;
            URS_SEL_HALF: next_level = count >= LVL_HALF;
            URS_SEL_3Q: next_level = count >= LVL_3Q;
            default: next_level = count != '0; // Reserved code acts as not-empty
        endcase
    end

    // Registered threshold flag so the output comes from a flop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_irq_flag <= 1'b0;
            prev_level <= 1'b0;
        end else if (clk_en) begin
            rx_irq_flag <= next_level;
            prev_level <= next_level;
        end
    end

    // ***************************************************
    // Control register writes
    // ***************************************************
    // Writable fields of the status and control register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_irq_threshold_sel <= URS_SEL_RESET;
            address_detect_enable <= 1'b0;
        end else if (clk_en && wr_status) begin
            rx_irq_threshold_sel <= reg_wdata[URS_STA_SEL_LO +: 2];
            address_detect_enable <= reg_wdata[URS_STA_ADDR_EN];
        end
    end

    // Overrun: set by overflow, cleared only by a software zero; set wins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overrun_error_flag <= 1'b0;
        end else if (clk_en) begin
            if (overflow) begin
                overrun_error_flag <= 1'b1;
            end else if (overrun_error_flag_clear) begin
                overrun_error_flag <= 1'b0;
            end
        end
    end

    // Character format and bit period
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode <= URS_MODE_RESET;
            bit_ticks <= URS_BAUD_RESET;
        end else if (clk_en && reg_write) begin
            if (reg_addr == URS_OFS_MODE) begin
                mode <= reg_wdata[2:0];
            end
            // A zero period would stall the sampler, so it is ignored
            if (reg_addr == URS_OFS_BAUD && reg_wdata[15:0] != 16'h0000) begin
                bit_ticks <= reg_wdata[15:0];
            end
        end
    end

    // ***************************************************
    // Interrupt status and mask
    // ***************************************************
    always_comb begin
        events = '0;
        events[URS_EV_LEVEL] = next_level && !prev_level;
        events[URS_EV_OVERRUN] = overflow && !overrun_error_flag;
        events[URS_EV_PARITY] = push && char_parity_error_flag;
        events[URS_EV_FRAMING] = push && char_framing_error_flag;
        events[URS_EV_ADDRESS] = push && mode[URS_MODE_NINE] && char_data[8];
    end

    // Sticky bits cleared by writing one; a new event outranks the clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_status <= '0;
            irq_mask <= URS_MASK_RESET;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (reg_write && reg_addr == URS_OFS_IRQ_STAT) begin
                irq_status <= (irq_status & ~reg_wdata[URS_IRQ_W-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            if (reg_write && reg_addr == URS_OFS_IRQ_MASK) begin
                irq_mask <= reg_wdata[URS_IRQ_W-1:0];
            end
            // One cycle behind the status bits, traded for a flop output
            irq <= |(irq_status & irq_mask);
        end
    end

    // ***************************************************
    // Read data
    // ***************************************************
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            URS_OFS_STATUS: begin
                next_rdata[URS_STA_SEL_LO +: 2] = rx_irq_threshold_sel;
                next_rdata[URS_STA_ADDR_EN] = address_detect_enable;
                next_rdata[URS_STA_IDLE] = receiver_idle_flag;
                next_rdata[URS_STA_PARITY_ERROR_FLAG] = parity_error_flag;
                next_rdata[URS_STA_FRAMING_ERROR_FLAG] = framing_error_flag;
                next_rdata[URS_STA_OVERRUN_ERROR_FLAG] = overrun_error_flag;
                next_rdata[URS_STA_AVAIL] = rx_data_available;
            end
            URS_OFS_MODE: next_rdata[2:0] = mode;
            URS_OFS_BAUD: next_rdata[15:0] = bit_ticks;
            URS_OFS_DATA: next_rdata[8:0] = empty ? 9'h000 : head[8:0];
            URS_OFS_IRQ_STAT: next_rdata[URS_IRQ_W-1:0] = irq_status;
            URS_OFS_IRQ_MASK: next_rdata[URS_IRQ_W-1:0] = irq_mask;
            default: next_rdata = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= reg_read ? next_rdata : '0;
        end
    end
endmodule
`default_nettype wire

//--- bench/urs_rx_status_properties.sv
`default_nettype none
module urs_rx_status_checker
    import urs_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic rx_line,
    input wire logic rx_irq_flag,
    input wire logic irq
);
    // ********
    // Shadow of what software wrote and read
    // ********
    logic st_rd;
    logic st_wr;
    logic last_st;
    logic overrun_error_flag_seen;
    logic [1:0] sel;
    logic [4:0] mask;
    assign st_rd = reg_read && clk_en && reg_addr == URS_OFS_STATUS;
    assign st_wr = reg_write && clk_en && reg_addr == URS_OFS_STATUS;
    // Overrun seen is kept only until software clears it, so a set-wins race stays harmless
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            last_st <= 1'b0;
            overrun_error_flag_seen <= 1'b0;
            sel <= URS_SEL_RESET;
            mask <= URS_MASK_RESET;
        end else begin
            last_st <= st_rd;
            if (st_wr) begin
                sel <= reg_wdata[7:6];
            end
            if (reg_write && clk_en && reg_addr == URS_OFS_IRQ_MASK) begin
                mask <= reg_wdata[4:0];
            end
            if (st_wr && !reg_wdata[URS_STA_OVERRUN_ERROR_FLAG]) begin
                overrun_error_flag_seen <= 1'b0;
            end else if (last_st && reg_rdata[URS_STA_OVERRUN_ERROR_FLAG]) begin
                overrun_error_flag_seen <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    rdata_quiet_a: assert property ($past(clk_en) && !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    status_upper_a: assert property (last_st |-> reg_rdata[31:8] == 24'h00_0000)
        else $error("status upper bits not zero");
    // A low stop bit leaves one idle sample on a low line, so only a fresh fall proves busy
    idle_busy_a: assert property (st_rd && !rx_line && !$past(rx_line) && $past(rx_line, 2)
        && $past(clk_en) && !$past(st_wr) |=> !reg_rdata[URS_STA_IDLE]) else $error("idle after start edge");
    flag_any_a: assert property (last_st && $past(sel) == URS_SEL_ANY |->
        rx_irq_flag == reg_rdata[URS_STA_AVAIL]) else $error("flag differs from data available");
    empty_low_a: assert property (last_st && !reg_rdata[URS_STA_AVAIL] |-> !rx_irq_flag)
        else $error("flag high with empty buffer");
    masked_quiet_a: assert property (mask == 5'h00 && $past(mask) == 5'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    overrun_error_flag_sticky_a: assert property (last_st && overrun_error_flag_seen |-> reg_rdata[URS_STA_OVERRUN_ERROR_FLAG])
        else $error("overrun cleared without software");
    flush_empty_a: assert property (st_wr && !reg_wdata[URS_STA_OVERRUN_ERROR_FLAG] && overrun_error_flag_seen ##2 st_rd
        |=> reg_rdata[1:0] == 2'b00) else $error("buffer not emptied by overrun clear");
    cover property (last_st && reg_rdata[URS_STA_OVERRUN_ERROR_FLAG]);
    cover property (rx_irq_flag && sel == URS_SEL_3Q);
    cover property (irq);
endmodule
bind urs_rx_status urs_rx_status_checker #(.DEPTH(DEPTH)) u_urs_rx_status_checker (.clock(clock),
    .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_line(rx_line), .rx_irq_flag(rx_irq_flag), .irq(irq));
`default_nettype wire

//--- bench/urs_tx_model.sv
`default_nettype none
module urs_tx_model (
    input wire logic clock,
    input wire logic [15:0] bit_ticks,
    output logic tx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Line idles high between frames
    initial tx_line = 1'b1;
    // One bit cell, changed just after an edge
    task automatic put(input logic b);
        tx_line <= b;
        repeat (bit_ticks) @(posedge clock);
    endtask
    // Frame LSB first; the trailing idle cell keeps the next start edge visible after a low stop
    task automatic send(input logic [8:0] d, input logic nine, input logic pe, input logic bad_par,
        input logic bad_stop);
        put(1'b0);
        for (int i = 0; i < 9; i++) begin
            if (i < 8 || nine) put(d[i]);
        end
        if (pe) put(^d[7:0] ^ bad_par);
        put(~bad_stop);
        put(1'b1);
    endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`default_nettype none
module tb_top;
    import urs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 8;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic rx_line;
    logic rx_irq_flag;
    logic irq;
    int n_errors = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h71ba_faec;
    logic [31:0] rv;
    logic [8:0] q[$];
    // ********
    // Clock, design and far-side transmitter
    // ********
    always #10 clock = ~clock;
    urs_rx_status #(.DEPTH(D)) u_urs_rx_status (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rx_line(rx_line), .rx_irq_flag(rx_irq_flag), .irq(irq));
    urs_tx_model u_urs_tx_model (.clock(clock), .bit_ticks(16'h0008), .tx_line(rx_line));
    // Bench helpers; every task is entered just after a rising edge
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic int thr(input int s);
        return s == 0 ? 1 : (s == 1 ? D / 2 : 3 * D / 4);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        // Idle cycle so a following write never re-raises the strobe in the same step
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic send8();
        seed = xs(seed);
        q.push_back({1'b0, seed[7:0]});
        u_urs_tx_model.send(q[$], 1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0010, rv);
        rd(URS_OFS_IRQ_MASK, rv); chk("mask", 32'h0000_0000, rv);
        rd(8'h20, rv); chk("unmapped", 32'h0000_0000, rv);
        // A frozen block ignores the bus
        clk_en <= 1'b0;
        wr(URS_OFS_IRQ_MASK, 32'h0000_001F);
        clk_en <= 1'b1;
        rd(URS_OFS_IRQ_MASK, rv); chk("frozen", 32'h0000_0000, rv);
        wr(URS_OFS_BAUD, 32'h0000_0008);
        $display("test reset done");
        // Fill then drain at each legal threshold; the reserved code is never written
        for (int s = 0; s < 3; s++) begin
            wr(URS_OFS_STATUS, 32'(s) << 6);
            for (int i = 1; i <= D; i++) begin
                send8();
                repeat (3) @(posedge clock);
                chk("irq_flag", 32'(i >= thr(s)), 32'(rx_irq_flag));
            end
            for (int i = D - 1; i >= 0; i--) begin
                rd(URS_OFS_DATA, rv); chk("data", 32'(q.pop_front()), rv);
                repeat (2) @(posedge clock);
                chk("irq_flag", 32'(i >= thr(s)), 32'(rx_irq_flag));
            end
            rd(URS_OFS_STATUS, rv); chk("status", (32'(s) << 6) | 32'h0000_0010, rv);
        end
        $display("test threshold done");
        // Parity and framing faults, interrupt raise, mask and clear
        wr(URS_OFS_STATUS, 32'h0000_0000);
        wr(URS_OFS_IRQ_STAT, 32'h0000_001F);
        wr(URS_OFS_MODE, 32'h0000_0002);
        u_urs_tx_model.send(9'h0A5, 1'b0, 1'b1, 1'b1, 1'b0);
        repeat (3) @(posedge clock);
        chk("irq", 32'h0, 32'(irq));
        rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0019, rv);
        rd(URS_OFS_IRQ_STAT, rv); chk("irq_stat", 32'h0000_0005, rv);
        wr(URS_OFS_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge clock);
        chk("irq", 32'h1, 32'(irq));
        wr(URS_OFS_IRQ_STAT, 32'h0000_0004);
        repeat (2) @(posedge clock);
        chk("irq", 32'h0, 32'(irq));
        rd(URS_OFS_DATA, rv); rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0010, rv);
        u_urs_tx_model.send(9'h03C, 1'b0, 1'b1, 1'b0, 1'b1);
        rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0015, rv);
        rd(URS_OFS_DATA, rv); rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0010, rv);
        $display("test errors done");
        // Idle flag mid-frame, then overflow, sticky overrun and flush
        wr(URS_OFS_MODE, 32'h0000_0000);
        fork
            send8();
            begin
                repeat (1) @(posedge clock);
                rd(URS_OFS_STATUS, rv); chk("idle", 32'h0, 32'(rv[URS_STA_IDLE]));
            end
        join
        repeat (D) send8();
        rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0013, rv);
        rd(URS_OFS_DATA, rv); rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0013, rv);
        wr(URS_OFS_STATUS, 32'h0000_0002); rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0013, rv);
        wr(URS_OFS_STATUS, 32'h0000_0000); rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0010, rv);
        $display("test overrun done");
        // Address detect in 9-bit mode and its absence in 8-bit mode
        wr(URS_OFS_MODE, 32'h0000_0001);
        wr(URS_OFS_STATUS, 32'h0000_0020);
        u_urs_tx_model.send(9'h055, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(URS_OFS_STATUS, rv); chk("status", 32'h0000_0030, rv);
        u_urs_tx_model.send(9'h1A5, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(URS_OFS_DATA, rv); chk("data", 32'h0000_01A5, rv);
        wr(URS_OFS_MODE, 32'h0000_0000);
        u_urs_tx_model.send(9'h033, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(URS_OFS_DATA, rv); chk("data", 32'h0000_0033, rv);
        $display("test address done");
        wrap_up();
    end
endmodule
`default_nettype wire
